// >>> hdl/lcd_cfg_pkg.sv
// constants and carrier types for the lcd pin, duty and power configuration block
// assumes an ahb-lite slave with 32-bit data and one clock
//
// Operation
// - pin/duty register, eight bits, resets to zero
// - bits 7:6 pick static, 1/2, 1/3, 1/4
// - unmirrored duty drives only its backplane pins
// - static mirrored copies backplane 1 to 2-4
// - half mirrored copies 1->2, 3->4; third not
// - bit 4 turns pins 32-29 into expansion
// - segment-select groups of eight become segments
// - control register resets to hex 80
// - control bit 7 reads one, ignores writes
// - bit 6 switches drive power on
// - power off when halted or in standby
// - bit 5 runs controller, halting keeps registers
// - low four bits select frame clock source
package lcd_cfg_pkg;

    localparam logic [31:0] PIN_DUTY_ADDR     = 32'h0000_0000;
    localparam logic [31:0] POWER_CTRL_ADDR   = 32'h0000_0004;
    localparam int          ADDR_DECODE_BITS  = 8;

    localparam logic [7:0]  PIN_DUTY_RESET    = 8'h00;
    localparam logic [7:0]  POWER_CTRL_RESET  = 8'h80;
    localparam logic [7:0]  POWER_CTRL_FIXED1 = 8'h80;

    localparam int DUTY_HI_POS   = 7;
    localparam int DUTY_LO_POS   = 6;
    localparam int MIRROR_POS    = 5;
    localparam int EXPAND_POS    = 4;
    localparam int POWER_POS     = 6;
    localparam int RUN_POS       = 5;
    localparam int SHOW_RAM_POS  = 4;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;

    localparam int SEG_PINS   = 32;
    localparam int SEG_GROUPS = 4;
    localparam int BP_PINS    = 4;

    typedef enum logic [1:0] {
        DUTY_STATIC,
        DUTY_HALF,
        DUTY_THIRD,
        DUTY_QUARTER
    } duty_t;

    typedef struct packed {
        logic [7:0] pin_duty;
        logic [7:0] power_ctrl;
        logic       pend_wr;
        logic [1:0] pend_sel;
        logic [31:0] rdata;
    } cfg_state_t;

    typedef struct packed {
        duty_t                   duty;
        logic [BP_PINS-1:0]      bp_drive;
        logic [BP_PINS-1:0]      bp_source_hi;
        logic [BP_PINS-1:0]      bp_source_lo;
        logic [SEG_PINS-1:0]     seg_drive;
        logic                    expansion_on;
        logic                    drive_power_on;
        logic                    run;
        logic                    show_ram_contents;
        logic [3:0]              frame_clock_select;
    } lcd_cfg_t;

endpackage : lcd_cfg_pkg

// >>> hdl/lcd_pin_duty_power_config.sv
// lcd pin function, backplane mirroring and drive power configuration
// assumes one ahb-lite master, hsel from an outside decoder, word transfers
//
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module lcd_pin_duty_power_config (
    // clock and reset
    input  wire logic                ref_clk_i,
    input  wire logic                nrst_i,
    // ahb-lite slave
    input  wire logic                hsel_i,
    input  wire logic [31:0]         haddr_i,
    input  wire logic [1:0]          htrans_i,
    input  wire logic                hwrite_i,
    input  wire logic [2:0]          hsize_i,
    input  wire logic [31:0]         hwdata_i,
    input  wire logic                hready_i,
    output logic      [31:0]         hrdata_o,
    output logic                     hreadyout_o,
    output logic                     hresp_o,
    // chip state
    input  wire logic                standby_i,
    // decoded configuration
    output lcd_cfg_pkg::lcd_cfg_t    cfg_o
);
    import lcd_cfg_pkg::*;

    cfg_state_t s_q;
    cfg_state_t s_d;

    function automatic logic [1:0] reg_sel(input logic [31:0] a);
        if (a[ADDR_DECODE_BITS-1:0] == PIN_DUTY_ADDR[ADDR_DECODE_BITS-1:0]) begin
            return 2'h1;
        end else if (a[ADDR_DECODE_BITS-1:0] == POWER_CTRL_ADDR[ADDR_DECODE_BITS-1:0]) begin
            return 2'h2;
        end
        return 2'h0;
    endfunction

    logic addr_valid;
    assign addr_valid = hsel_i && hready_i
                        && (htrans_i == HTRANS_NONSEQ || htrans_i == HTRANS_SEQ);

    // zero wait states: write data lands one cycle after its address phase
    always_comb begin
        s_d = s_q;
        s_d.pend_wr = addr_valid && hwrite_i;
        s_d.pend_sel = addr_valid ? reg_sel(haddr_i) : 2'h0;
        if (s_q.pend_wr && s_q.pend_sel == 2'h1) begin
            s_d.pin_duty = hwdata_i[7:0];
        end
        if (s_q.pend_wr && s_q.pend_sel == 2'h2) begin
            // top bit kept at one whatever is written
            s_d.power_ctrl = hwdata_i[7:0] | POWER_CTRL_FIXED1;
        end
        s_d.rdata = 32'h0000_0000;
        if (addr_valid && !hwrite_i) begin
            // read the value after this edge, so a read right behind a write sees the write
            case (reg_sel(haddr_i))
                2'h1:    s_d.rdata = {24'h00_0000, s_d.pin_duty};
                2'h2:    s_d.rdata = {24'h00_0000, s_d.power_ctrl};
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q.pin_duty   <= PIN_DUTY_RESET;
            s_q.power_ctrl <= POWER_CTRL_RESET;
            s_q.pend_wr    <= 1'b0;
            s_q.pend_sel   <= 2'h0;
            s_q.rdata      <= 32'h0000_0000;
        end else begin
            s_q <= s_d;
        end
    end

    assign hrdata_o    = s_q.rdata;
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;

    // decode straight from the registers, so a write shows the next cycle
    logic [3:0] sgs;
    logic       mirror;
    logic       expand;
    duty_t      duty;
    assign sgs    = s_q.pin_duty[3:0];
    assign mirror = s_q.pin_duty[MIRROR_POS];
    assign expand = s_q.pin_duty[EXPAND_POS];
    assign duty   = duty_t'(s_q.pin_duty[DUTY_HI_POS:DUTY_LO_POS]);

    // number of groups of eight counted down from pin 32
    logic [2:0] seg_groups;
    always_comb begin
        if (expand) begin
            seg_groups = 3'h0;
        end else if (sgs[3]) begin
            seg_groups = 3'h4;
        end else if (sgs[2:1] == 2'h0) begin
            seg_groups = 3'h0;
        end else begin
            seg_groups = {1'b0, sgs[2:1]};
        end
    end

    logic [SEG_PINS-1:0] seg_drive;
    genvar g;
    generate
        for (g = 0; g < SEG_GROUPS; g++) begin : gen_group
            // group 3 is pins 32-25; non-segment pins go to port logic
            assign seg_drive[g*8 +: 8] =
                {8{(3'(SEG_GROUPS - g)) <= seg_groups}};
        end
    endgenerate

    // bp_source_hi/lo: bit n is which driven backplane pin n copies (index)
    logic [BP_PINS-1:0] bp_drive;
    logic [BP_PINS-1:0] src_hi;
    logic [BP_PINS-1:0] src_lo;
    // mirrored half duty: pin 2 copies pin 1, pin 4 copies pin 3
    always_comb begin
        bp_drive = 4'h0;
        src_hi   = 4'h0;
        src_lo   = 4'h0;
        case (duty)
            DUTY_STATIC: begin
                bp_drive = mirror ? 4'hF : 4'h1;
            end
            DUTY_HALF: begin
                bp_drive = mirror ? 4'hF : 4'h3;
                src_hi   = mirror ? 4'hC : 4'h0;
                src_lo   = mirror ? 4'h0 : 4'h2;
            end
            DUTY_THIRD: begin
                bp_drive = 4'h7;
                src_hi   = 4'h4;
                src_lo   = 4'h2;
            end
            DUTY_QUARTER: begin
                bp_drive = 4'hF;
                src_hi   = 4'hC;
                src_lo   = 4'hA;
            end
            default: begin
                bp_drive = 4'h0;
            end
        endcase
    end

    always_comb begin
        cfg_o                    = '0;
        cfg_o.duty               = duty;
        cfg_o.bp_drive           = bp_drive;
        cfg_o.bp_source_hi       = src_hi;
        cfg_o.bp_source_lo       = src_lo;
        cfg_o.seg_drive          = seg_drive;
        cfg_o.expansion_on       = expand;
        cfg_o.run                = s_q.power_ctrl[RUN_POS];
        cfg_o.show_ram_contents  = s_q.power_ctrl[SHOW_RAM_POS];
        cfg_o.frame_clock_select = s_q.power_ctrl[3:0];
        cfg_o.drive_power_on     = s_q.power_ctrl[POWER_POS]
                                   && s_q.power_ctrl[RUN_POS] && !standby_i;
    end

    // bus steps that the checks below build on: an address phase taken at one edge,
    // then its data phase in the next cycle
    sequence pin_wr_addr_s;
        addr_valid && hwrite_i && reg_sel(haddr_i) == 2'h1;
    endsequence

    sequence pwr_wr_addr_s;
        addr_valid && hwrite_i && reg_sel(haddr_i) == 2'h2;
    endsequence

    sequence odd_wr_addr_s;
        addr_valid && hwrite_i && reg_sel(haddr_i) == 2'h0;
    endsequence

    sequence pin_write_s;
        pin_wr_addr_s ##1 1'b1;
    endsequence

    sequence pwr_write_s;
        pwr_wr_addr_s ##1 1'b1;
    endsequence

    sequence odd_write_s;
        odd_wr_addr_s ##1 1'b1;
    endsequence

    sequence pin_read_s;
        addr_valid && !hwrite_i && reg_sel(haddr_i) == 2'h1;
    endsequence

    sequence pwr_read_s;
        addr_valid && !hwrite_i && reg_sel(haddr_i) == 2'h2;
    endsequence

    // power gating
    bit_seven_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        s_q.power_ctrl[7])
        else $error("control bit 7 not one");

    power_gate_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (!s_q.power_ctrl[RUN_POS] || standby_i) |-> !cfg_o.drive_power_on)
        else $error("drive power on while halted");

    power_on_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (s_q.pend_wr && s_q.pend_sel == 2'h2 && hwdata_i[POWER_POS] && hwdata_i[RUN_POS])
        ##1 !standby_i |-> cfg_o.drive_power_on)
        else $error("power switch not applied");

    power_follow_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (s_q.power_ctrl[POWER_POS] && s_q.power_ctrl[RUN_POS] && !standby_i)
        |-> cfg_o.drive_power_on) else $error("drive power off although switched on");

    // backplane map
    static_mirror_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (duty == DUTY_STATIC && mirror) |-> bp_drive == 4'hF)
        else $error("static mirror not on all backplanes");

    static_src_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        duty == DUTY_STATIC |-> (src_hi == 4'h0 && src_lo == 4'h0))
        else $error("static backplanes not copies of backplane 1");

    no_mirror_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        !mirror |-> bp_drive == 4'((5'h1 << (5'(duty) + 5'h1)) - 5'h1))
        else $error("wrong backplane count");

    half_plain_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (duty == DUTY_HALF && !mirror) |-> (src_hi == 4'h0 && src_lo == 4'h2))
        else $error("half duty backplanes not their own");

    half_mirror_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (duty == DUTY_HALF && mirror)
        |-> (bp_drive == 4'hF && src_hi == 4'hC && src_lo == 4'h0))
        else $error("half duty mirror sources wrong");

    third_bp4_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        duty == DUTY_THIRD |-> !bp_drive[3]) else $error("backplane 4 used in third");

    third_map_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        duty == DUTY_THIRD |-> (src_hi == 4'h4 && src_lo == 4'h2))
        else $error("third duty backplane sources wrong");

    quarter_map_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        duty == DUTY_QUARTER
        |-> (bp_drive == 4'hF && src_hi == 4'hC && src_lo == 4'hA))
        else $error("quarter duty backplanes not their own");

    // segment map
    seg_full_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (!expand && sgs[3]) |-> &seg_drive) else $error("full segment map wrong");

    seg_none_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (!expand && sgs[3:1] == 3'h0) |-> seg_drive == 32'h0000_0000)
        else $error("segments in port-only map");

    seg_top_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (!expand && sgs[3:1] != 3'h0) |-> &seg_drive[SEG_PINS-1 -: 8])
        else $error("pins 32-25 not segments");

    seg_low_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (!expand && !sgs[3]) |-> seg_drive[7:0] == 8'h00)
        else $error("pins 8-1 not ports");

    expand_port_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        expand |-> seg_drive == 32'h0000_0000) else $error("segments in expansion");

    // register bus
    write_next_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (s_q.pend_wr && s_q.pend_sel == 2'h1) |=> s_q.pin_duty == $past(hwdata_i[7:0]))
        else $error("pin register write lost");

    pin_land_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        pin_write_s |=> s_q.pin_duty == $past(hwdata_i[7:0]))
        else $error("pin register write not landed");

    pwr_land_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        pwr_write_s |=> s_q.power_ctrl == ($past(hwdata_i[7:0]) | POWER_CTRL_FIXED1))
        else $error("control register write not landed");

    odd_write_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        odd_write_s |=> ($stable(s_q.pin_duty) && $stable(s_q.power_ctrl)))
        else $error("unmapped write changed a register");

    regs_hold_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        !s_q.pend_wr |=> ($stable(s_q.pin_duty) && $stable(s_q.power_ctrl)))
        else $error("register changed without a write");

    pin_rd_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        pin_read_s |=> hrdata_o == {24'h00_0000, s_q.pin_duty})
        else $error("pin register read wrong");

    pwr_rd_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        pwr_read_s |=> hrdata_o == {24'h00_0000, s_q.power_ctrl})
        else $error("control register read wrong");

    read_idle_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        !(addr_valid && !hwrite_i) |=> hrdata_o == 32'h0000_0000)
        else $error("read data outside a read");

endmodule // lcd_pin_duty_power_config

`default_nettype wire

// >>> test/lcd_panel_model.sv
// stand-in for the panel: counts the common lines it sees driven
// assumes cfg_o of the configuration block is wired straight to it
`timescale 1ns/1ps
`default_nettype none

module lcd_panel_model (
    // decoded configuration
    input  wire lcd_cfg_pkg::lcd_cfg_t cfg_i,
    // panel view
    output logic [2:0]                 com_lines_o
);
    import lcd_cfg_pkg::*;
    // a panel only sees lines that are driven, unused ones float
    always_comb com_lines_o = 3'($countones(cfg_i.bp_drive));
endmodule // lcd_panel_model

`default_nettype wire

// >>> test/testbench.sv
// self-checking bench for the lcd pin, duty and power configuration block
// assumes a zero-wait ahb-lite slave, one master, word transfers only
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    $display("wrong value %s exp %0h got %0h", nm, e, g); bad_count++; end end

module testbench;
    import lcd_cfg_pkg::*;
    logic        ref_clk_i, nrst_i, hsel_i, hwrite_i, standby_i, hreadyout_o, hresp_o;
    logic [31:0] haddr_i, hwdata_i, hrdata_o, es;
    logic [1:0]  htrans_i, idx;
    lcd_cfg_t    cfg_o;
    logic [2:0]  com_lines, dm;
    logic [3:0]  drv, hi, lo, sv;
    logic [7:0]  pv [5] = '{8'h7F, 8'h7F, 8'h40, 8'h20, 8'h6A};
    logic        sb [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    logic        ep [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    int          bad_count = 0;
    int          n_checks = 0;

    lcd_pin_duty_power_config u_dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
        .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .standby_i(standby_i), .cfg_o(cfg_o));
    lcd_panel_model u_panel (.cfg_i(cfg_o), .com_lines_o(com_lines));

    always #10 ref_clk_i = ~ref_clk_i;

    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge ref_clk_i);
        hsel_i <= 1'b1;
        haddr_i <= a;
        hwrite_i <= w;
        htrans_i <= HTRANS_NONSEQ;
        @(posedge ref_clk_i);
        while (hreadyout_o !== 1'b1) @(posedge ref_clk_i);
        htrans_i <= 2'h0;
        hsel_i <= 1'b0;
        hwdata_i <= d;
        @(posedge ref_clk_i);
        while (hreadyout_o !== 1'b1) @(posedge ref_clk_i);
        r = hrdata_o;
        @(negedge ref_clk_i);
    endtask

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, a, {24'h0, d}, r);
    endtask

    task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        `CHK(nm, e, r)
    endtask

    task print_verdict;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // generous bound: the sequence needs well under a thousand cycles
    initial begin
        #400000;
        bad_count++;
        print_verdict;
    end

    initial begin
        ref_clk_i = 1'b0;
        nrst_i <= 1'b0;
        hsel_i <= 1'b0;
        haddr_i <= 32'h0;
        htrans_i <= 2'h0;
        hwrite_i <= 1'b0;
        hwdata_i <= 32'h0;
        standby_i <= 1'b0;
        repeat (12) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        rchk("pin_duty reset", PIN_DUTY_ADDR, 32'h00);
        rchk("power reset", POWER_CTRL_ADDR, 32'h80);
        `CHK("okay resp", 1'b0, hresp_o)
        `CHK("bp reset", 4'h1, cfg_o.bp_drive)
        `CHK("seg reset", 32'h0, cfg_o.seg_drive)
        `CHK("power on reset", 1'b0, cfg_o.drive_power_on)
        for (int i = 0; i < 8; i++) begin
            dm = 3'(i);
            wr(PIN_DUTY_ADDR, {dm, 5'h00});
            drv = (dm[0] && dm[2:1] != 2'h2) ? 4'hF : 4'((5'h2 << dm[2:1]) - 5'h1);
            for (int n = 0; n < 4; n++) begin
                idx = (!dm[0] || dm[2:1] > 2'h1) ? 2'(n) : (dm[2:1] == 2'h0) ? 2'h0 : 2'(n & 2);
                hi[n] = idx[1];
                lo[n] = idx[0];
            end
            `CHK("duty", dm[2:1], 2'(cfg_o.duty))
            `CHK("bp drive", drv, cfg_o.bp_drive)
            `CHK("src hi", hi & drv, cfg_o.bp_source_hi & drv)
            `CHK("src lo", lo & drv, cfg_o.bp_source_lo & drv)
            `CHK("com lines", 3'($countones(drv)), com_lines)
            rchk("pin_duty back", PIN_DUTY_ADDR, {24'h0, dm, 5'h00});
        end
        for (int s = 0; s < 16; s++) begin
            sv = 4'(s);
            wr(PIN_DUTY_ADDR, {4'h0, sv});
            es = sv[3] ? 32'hFFFF_FFFF : (sv[2:1] == 2'h0) ? 32'h0 : ~(32'hFFFF_FFFF >> (8 * sv[2:1]));
            `CHK("seg map", es, cfg_o.seg_drive)
            `CHK("exp off", 1'b0, cfg_o.expansion_on)
        end
        wr(PIN_DUTY_ADDR, 8'h10);
        `CHK("exp on", 1'b1, cfg_o.expansion_on)
        `CHK("exp ports", 32'h0, cfg_o.seg_drive)
        for (int k = 0; k < 5; k++) begin
            @(posedge ref_clk_i);
            standby_i <= sb[k];
            wr(POWER_CTRL_ADDR, pv[k]);
            `CHK("power", ep[k], cfg_o.drive_power_on)
            `CHK("run", pv[k][5], cfg_o.run)
            `CHK("show ram", pv[k][4], cfg_o.show_ram_contents)
            `CHK("frame clk", pv[k][3:0], cfg_o.frame_clock_select)
            rchk("power back", POWER_CTRL_ADDR, {24'h0, pv[k] | 8'h80});
        end
        rchk("pin_duty kept", PIN_DUTY_ADDR, 32'h10);
        wr(32'h0000_0008, 8'hFF);
        rchk("unmapped", 32'h0000_0008, 32'h0);
        rchk("pin_duty intact", PIN_DUTY_ADDR, 32'h10);
        rchk("power intact", POWER_CTRL_ADDR, 32'hEA);
        print_verdict;
    end
endmodule // testbench

`default_nettype wire
